// ---- rtl/twb_pkg.sv ----
// Constants and carrier types for the transparent write block transfer engine
package twb_pkg;

	// ****************************************
	// Register map (indices; byte address = index * 4)
	// ****************************************
	localparam logic [8:0] IDX_CTRL = 9'h100;
	localparam logic [8:0] IDX_FMT = 9'h101;
	localparam logic [8:0] IDX_OP = 9'h103;
	localparam logic [8:0] IDX_SRC0 = 9'h104;
	localparam logic [8:0] IDX_DST0 = 9'h108;
	localparam logic [8:0] IDX_DST1 = 9'h109;
	localparam logic [8:0] IDX_DST2 = 9'h10a;
	localparam logic [8:0] IDX_STR_LO = 9'h10c;
	localparam logic [8:0] IDX_STR_HI = 9'h10d;
	localparam logic [8:0] IDX_WID_LO = 9'h110;
	localparam logic [8:0] IDX_WID_HI = 9'h111;
	localparam logic [8:0] IDX_HGT_LO = 9'h112;
	localparam logic [8:0] IDX_HGT_HI = 9'h113;
	localparam logic [8:0] IDX_COL_LO = 9'h114;
	localparam logic [8:0] IDX_COL_HI = 9'h115;
	localparam logic [8:0] IDX_LINSEL = 9'h11c;
	localparam logic [4:0] REG_PAGE = 5'h08;
	localparam logic [11:0] DATA_ADDR = 12'h800;

	// ****************************************
	// Field values and bit positions
	// ****************************************
	localparam logic [7:0] OP_TWRITE = 8'h04;
	localparam logic [7:0] FMT_8BPP = 8'h00;
	localparam logic [7:0] FMT_16BPP = 8'h01;
	localparam int unsigned CTRL_ACTIVE = 7;
	localparam int unsigned CTRL_HALF = 6;
	localparam int unsigned CTRL_NEMPTY = 5;
	localparam int unsigned CTRL_FULL = 4;
	localparam int unsigned CTRL_DONE = 3;
	localparam int unsigned LIN_SRC = 0;
	localparam int unsigned LIN_DST = 1;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ****************************************
	// Write queue
	// ****************************************
	localparam int unsigned FIFO_DEPTH = 16;
	localparam logic [4:0] FIFO_FULL = 5'h10;
	localparam logic [4:0] FIFO_HALF = 5'h08;

	typedef enum logic [1:0] {
		TWB_IDLE = 2'b00,
		TWB_RUN = 2'b01,
		TWB_DONE = 2'b10
	} twb_state_t;

	// One display buffer write request
	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] data;
		logic [1:0] be;
	} twb_mem_wr_t;

endpackage

// ---- rtl/twb_engine.sv ----
// Transparent write block transfer engine with APB registers and write queue
// Register window
// Each configuration register is one byte in its own aligned word slot.
// The byte address of a slot is its index times four.
// Upper read data bits are always zero.
// Unmapped addresses answer with pslverr and store nothing.
// Writes to the control slot are never stored; they only start a transfer.
// A start is ignored unless the engine is idle and fully configured.
// Fully configured means the operation code and a known colour format.
//
// Data window
// Each host write to the data window during a transfer pushes its low half word.
// A wide host write must be split into two half word writes upstream.
// Words beyond the expected count are dropped, not queued.
// Words written while the queue is full are dropped as well.
// A read of the data window returns zero.
// Once the engine is done, that read returns the engine to idle.
//
// Write queue
// Sixteen half words of flip-flop storage with a fill counter.
// Full, half full and not empty come straight from the counter.
// The queue is flushed at every start, so stale words never leak.
//
// Pixel engine
// One pixel is stepped per cycle while a word waits in the queue.
// A step is held back while a display write is still unacknowledged.
// Transparent pixels step without a display write.
// At 8 bpp a byte select walks the low and high halves of each word.
// The select restarts from the source phase at every line.
// A word is released after its high byte or at the end of a line.
// Lines advance by the stride in rectangular mode.
// Lines follow on directly in linear mode.
//
// Hazards
// Software must not change configuration while a transfer runs.
// The queue storage has no reset; only counted entries are ever read.
// The display write request stands until acknowledged, data unchanged.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module twb_engine (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output twb_pkg::twb_mem_wr_t mem_wr,
	output logic mem_req,
	input wire logic mem_ack
);

	// ****************************************
	// Register slot decode
	// ****************************************

	// True for slots that hold a register
	function automatic logic slot_mapped(input logic [4:0] s);
		slot_mapped = (s == twb_pkg::IDX_CTRL[4:0]) || (s == twb_pkg::IDX_FMT[4:0])
			|| (s == twb_pkg::IDX_OP[4:0]) || (s == twb_pkg::IDX_SRC0[4:0])
			|| (s == twb_pkg::IDX_DST0[4:0]) || (s == twb_pkg::IDX_DST1[4:0])
			|| (s == twb_pkg::IDX_DST2[4:0]) || (s == twb_pkg::IDX_STR_LO[4:0])
			|| (s == twb_pkg::IDX_STR_HI[4:0]) || (s == twb_pkg::IDX_WID_LO[4:0])
			|| (s == twb_pkg::IDX_WID_HI[4:0]) || (s == twb_pkg::IDX_HGT_LO[4:0])
			|| (s == twb_pkg::IDX_HGT_HI[4:0]) || (s == twb_pkg::IDX_COL_LO[4:0])
			|| (s == twb_pkg::IDX_COL_HI[4:0]) || (s == twb_pkg::IDX_LINSEL[4:0]);
	endfunction

	logic [7:0] regs_q [0:31];
	twb_pkg::twb_state_t state_q;
	logic [15:0] fifo_q [0:twb_pkg::FIFO_DEPTH-1];
	logic [3:0] wr_ptr_q;
	logic [3:0] rd_ptr_q;
	logic [4:0] cnt_q;
	logic [33:0] recv_q;
	logic [15:0] x_q;
	logic [15:0] y_q;
	logic sel_q;
	logic [23:0] cur_q;
	logic [23:0] line_q;
	logic mem_req_q;
	twb_pkg::twb_mem_wr_t mem_wr_q;
	logic [31:0] prdata_q;

	wire [4:0] slot = paddr[6:2];
	wire reg_hit = (paddr[11:7] == twb_pkg::REG_PAGE) && (paddr[1:0] == 2'b00);
	wire data_hit = (paddr == twb_pkg::DATA_ADDR);
	wire mapped = data_hit || (reg_hit && slot_mapped(slot));
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire apb_wr = access && pwrite && mapped;
	wire apb_rd = access && !pwrite && mapped;
	wire ctrl_hit = reg_hit && (slot == twb_pkg::IDX_CTRL[4:0]);

	// ****************************************
	// Configuration view of the register bytes
	// ****************************************

	// Destination bytes, least significant lowest
	wire [23:0] dest = {regs_q[twb_pkg::IDX_DST2[4:0]], regs_q[twb_pkg::IDX_DST1[4:0]],
		regs_q[twb_pkg::IDX_DST0[4:0]]};
	wire [15:0] stride = {regs_q[twb_pkg::IDX_STR_HI[4:0]], regs_q[twb_pkg::IDX_STR_LO[4:0]]};
	wire [15:0] wm1 = {regs_q[twb_pkg::IDX_WID_HI[4:0]], regs_q[twb_pkg::IDX_WID_LO[4:0]]};
	wire [15:0] hm1 = {regs_q[twb_pkg::IDX_HGT_HI[4:0]], regs_q[twb_pkg::IDX_HGT_LO[4:0]]};
	wire [15:0] colour = {regs_q[twb_pkg::IDX_COL_HI[4:0]], regs_q[twb_pkg::IDX_COL_LO[4:0]]};
	wire [7:0] fmt = regs_q[twb_pkg::IDX_FMT[4:0]];
	wire [7:0] op = regs_q[twb_pkg::IDX_OP[4:0]];
	wire phase = regs_q[twb_pkg::IDX_SRC0[4:0]][0];
	wire dlin = regs_q[twb_pkg::IDX_LINSEL[4:0]][twb_pkg::LIN_DST];

	// Pixel size: 00h gives 8 bpp, 01h gives 16 bpp
	wire bpp16 = (fmt == twb_pkg::FMT_16BPP);
	wire bpp8 = (fmt == twb_pkg::FMT_8BPP);
	wire [23:0] bpb = bpp16 ? 24'h000002 : 24'h000001;

	// Words the host must supply for the whole area
	wire [16:0] lines = {1'b0, hm1} + 17'h00001;
	wire [16:0] wpl16 = {1'b0, wm1} + 17'h00001;
	wire [17:0] wsum8 = {2'b00, wm1} + 18'h00002 + {17'h00000, phase};
	wire [16:0] wpl8 = wsum8[17:1];
	wire [16:0] wpl = bpp16 ? wpl16 : wpl8;
	wire [33:0] expected_word_count = wpl * lines;

	// ****************************************
	// Write queue flags
	// ****************************************
	wire q_full = (cnt_q == twb_pkg::FIFO_FULL);
	wire q_nempty = (cnt_q != 5'h00);
	wire q_half = (cnt_q >= twb_pkg::FIFO_HALF);
	wire running = (state_q == twb_pkg::TWB_RUN);
	wire finished = (state_q == twb_pkg::TWB_DONE) && !mem_req_q;

	// Each data window write is one word; extra words beyond the count are dropped
	wire push = apb_wr && data_hit && running && !q_full
		&& (recv_q < expected_word_count);

	// Status byte of the control register
	logic [7:0] status;
	always_comb begin
		status = 8'h00;
		status[twb_pkg::CTRL_ACTIVE] = (state_q != twb_pkg::TWB_IDLE);
		status[twb_pkg::CTRL_HALF] = q_half;
		status[twb_pkg::CTRL_NEMPTY] = q_nempty;
		status[twb_pkg::CTRL_FULL] = q_full;
		status[twb_pkg::CTRL_DONE] = finished;
	end

	// ****************************************
	// Pixel stepping
	// ****************************************

	// The head word is the oldest queued word.
	// A step consumes one pixel of it.
	// The step waits while a display write is pending and unacknowledged.
	// An acknowledge and the next step may share one edge.
	// That keeps back-to-back display writes possible.
	// Transparent pixels never raise a request.
	// The display location of a skipped pixel keeps its old contents.
	// At 8 bpp only the low byte of the colour is compared.
	// At 16 bpp the whole word is compared.
	// Destination address advances by one pixel size per step.
	// At line end the next line start is chosen by the layout bit.
	// Rectangular: previous line start plus stride in bytes.
	// Linear: directly after the previous line's last pixel.
	// The stride is held in words, so it is doubled into bytes.
	wire [15:0] head = fifo_q[rd_ptr_q];
	wire step = running && q_nempty && (!mem_req_q || mem_ack);
	wire last_x = (x_q == wm1);
	wire last_y = (y_q == hm1);
	wire [7:0] pix8 = sel_q ? head[15:8] : head[7:0];

	// Leave a word after its high byte or at line end
	wire pop = step && (bpp16 || sel_q || last_x);
	wire transp = bpp16 ? (head == colour) : (pix8 == colour[7:0]);
	wire [23:0] stride_b = {7'h00, stride, 1'b0};
	wire [23:0] next_line = dlin ? (cur_q + bpb) : (line_q + stride_b);
	wire start = apb_wr && ctrl_hit && pwdata[7] && (state_q == twb_pkg::TWB_IDLE)
		&& (op == twb_pkg::OP_TWRITE) && (bpp8 || bpp16);
	wire shutdown = apb_rd && data_hit && finished;

	// Memory request: set by a coloured pixel, dropped on acknowledge
	wire mem_req_d = step ? !transp : (mem_req_q && !mem_ack);

	// Registers keep any order of setup; control is never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 32; i++) begin
				regs_q[i] <= twb_pkg::REG_RESET;
			end
		end else if (apb_wr && reg_hit && !ctrl_hit) begin
			regs_q[slot] <= pwdata[7:0];
		end
	end

	// Transfer state: start, run to last pixel, wait for shutdown read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= twb_pkg::TWB_IDLE;
		end else begin
			unique case (state_q)
				twb_pkg::TWB_IDLE: begin
					if (start) begin
						state_q <= twb_pkg::TWB_RUN;
					end
				end
				twb_pkg::TWB_RUN: begin
					if (step && last_x && last_y) begin
						state_q <= twb_pkg::TWB_DONE;
					end
				end
				twb_pkg::TWB_DONE: begin
					if (shutdown) begin
						state_q <= twb_pkg::TWB_IDLE;
					end
				end
				default: begin
					state_q <= twb_pkg::TWB_IDLE;
				end
			endcase
		end
	end

	// Queue storage
	always_ff @(posedge pclk) begin
		if (push) begin
			fifo_q[wr_ptr_q] <= pwdata[15:0];
		end
	end

	// Queue pointers and fill level, flushed at start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_q <= 4'h0;
			rd_ptr_q <= 4'h0;
			cnt_q <= 5'h00;
			recv_q <= 34'h000000000;
		end else if (start) begin
			wr_ptr_q <= 4'h0;
			rd_ptr_q <= 4'h0;
			cnt_q <= 5'h00;
			recv_q <= 34'h000000000;
		end else begin
			wr_ptr_q <= wr_ptr_q + {3'h0, push};
			rd_ptr_q <= rd_ptr_q + {3'h0, pop};
			cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
			recv_q <= recv_q + {33'h000000000, push};
		end
	end

	// Position counters and destination address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			x_q <= 16'h0000;
			y_q <= 16'h0000;
			sel_q <= 1'b0;
			cur_q <= 24'h000000;
			line_q <= 24'h000000;
		end else if (start) begin
			x_q <= 16'h0000;
			y_q <= 16'h0000;
			sel_q <= bpp8 && phase;
			cur_q <= dest;
			line_q <= dest;
		end else if (step && last_x) begin
			x_q <= 16'h0000;
			y_q <= y_q + 16'h0001;
			sel_q <= bpp8 && phase;
			cur_q <= next_line;
			line_q <= next_line;
		end else if (step) begin
			x_q <= x_q + 16'h0001;
			sel_q <= bpp8 && !sel_q;
			cur_q <= cur_q + bpb;
		end
	end

	// Display buffer write request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req_q <= 1'b0;
			mem_wr_q <= '0;
		end else begin
			mem_req_q <= mem_req_d;
			if (step && !transp) begin
				mem_wr_q.addr <= cur_q;
				mem_wr_q.data <= bpp16 ? head : {pix8, pix8};
				mem_wr_q.be <= bpp16 ? 2'b11 : (cur_q[0] ? 2'b10 : 2'b01);
			end
		end
	end

	// ****************************************
	// APB read data, captured in the setup cycle
	// ****************************************

	// Read data is registered at the edge that ends the setup cycle.
	// It then stands through the access cycle until the next setup.
	// The slave never waits, so pready is tied high.
	// Status is a snapshot from the setup edge, one cycle old.
	// Software polls, so that lag costs nothing.
	// Unmapped reads return zero alongside pslverr.
	// Data window reads also return zero.
	// The data path is registered to keep the bus timing short.
	// Only the control slot returns live status; others echo storage.
	// Storage slots read back exactly what was last written.
	// The source linear bit is stored but has no effect here.
	// The source of pixel data is always the host queue.
	wire [7:0] reg_rd = ctrl_hit ? status : regs_q[slot];
	wire [31:0] rd_mux = (reg_hit && slot_mapped(slot)) ? {24'h000000, reg_rd} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (setup) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign mem_req = mem_req_q;
	assign mem_wr = mem_wr_q;

endmodule

`default_nettype wire

// ---- verif/twb_engine_sva.sv ----
// Port checker for the transparent write engine
`timescale 1ns/10ps
`default_nettype none
module twb_engine_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire twb_pkg::twb_mem_wr_t mem_wr,
	input wire logic mem_req,
	input wire logic mem_ack
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access cycle of a control register read
	sequence ctrl_rd;
		psel && penable && !pwrite && paddr == 12'h400;
	endsequence
	chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_wr))
		else $error("write request dropped or changed");
	chk_byte_lane: assert property (mem_req |-> mem_wr.be == 2'b11 ||
		mem_wr.be == {mem_wr.addr[0], !mem_wr.addr[0]}) else $error("bad byte lane");
	chk_byte_copy: assert property (mem_req && mem_wr.be != 2'b11 |->
		mem_wr.data[15:8] == mem_wr.data[7:0]) else $error("byte not on both lanes");
	chk_full_flags: assert property (ctrl_rd ##0 prdata[4] |-> prdata[6] && prdata[5])
		else $error("full without half and not empty");
	chk_half_flag: assert property (ctrl_rd ##0 prdata[6] |-> prdata[5])
		else $error("half full while empty");
	chk_done_active: assert property (ctrl_rd ##0 prdata[3] |-> prdata[7])
		else $error("done while inactive");
	chk_idle_quiet: assert property (ctrl_rd ##0 !prdata[7] |-> !mem_req)
		else $error("write while idle");
	chk_read_byte: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	cover property (ctrl_rd ##0 prdata[4]);
endmodule
bind twb_engine twb_engine_sva u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .mem_wr(mem_wr),
	.mem_req(mem_req), .mem_ack(mem_ack));
`default_nettype wire

// ---- verif/twb_mem_model.sv ----
// Display memory controller answering after a chosen lag
`timescale 1ns/10ps
`default_nettype none
module twb_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mem_req,
	input wire logic [3:0] lag,
	output logic mem_ack
);
	logic [3:0] wait_q;
	// Count cycles a request has waited
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wait_q <= 4'h0;
		else
			wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
	end
	assign mem_ack = mem_req && (wait_q >= lag);
endmodule
`default_nettype wire

// ---- verif/twb_engine_tb.sv ----
// Self-checking bench for the transparent write engine
`timescale 1ns/10ps
`default_nettype none
module twb_engine_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_ack, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] lag;
	logic [7:0] lfsr_q;
	twb_pkg::twb_mem_wr_t mem_wr;
	twb_pkg::twb_mem_wr_t exp_q[$];
	int num_errors, checks, cycles;
	logic [11:0] ra[15] = '{12'h404, 12'h40c, 12'h410, 12'h420, 12'h424, 12'h428, 12'h430,
		12'h434, 12'h440, 12'h444, 12'h448, 12'h44c, 12'h450, 12'h454, 12'h470};
	twb_engine DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_wr(mem_wr), .mem_req(mem_req), .mem_ack(mem_ack));
	twb_mem_model MEM (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .lag(lag),
		.mem_ack(mem_ack));
	// ****
	// Clock, random source, compares
	// ****
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	function automatic logic [7:0] rnd();
		lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		return lfsr_q;
	endfunction
	task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cmp_wr(input twb_pkg::twb_mem_wr_t e, input twb_pkg::twb_mem_wr_t g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected mem_wr exp %h got %h", e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang limit and display write monitor
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			complete_run();
		end
		if (presetn === 1'b1 && mem_req === 1'b1 && mem_ack === 1'b1) begin
			if (exp_q.size() == 0)
				cmp_byte("spare_write", 8'h00, 8'h01);
			else
				cmp_wr(exp_q.pop_front(), mem_wr);
		end
	end
	// ****
	// Bus tasks and transfer scenario
	// ****
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic poll(input int b, input logic v);
		do apb(1'b0, 12'h400, 32'h0); while (rd[b] !== v);
	endtask
	task automatic blit(input logic f, input int w, h, ph, input logic ln, input logic [3:0] lg);
		logic [15:0] col, wd;
		logic [7:0] px;
		logic [23:0] dst, a;
		logic [7:0] v[15];
		logic [15:0] words[$];
		int nw, ix;
		col = {rnd(), rnd()};
		dst = {8'h01, rnd(), rnd()};
		nw = f ? w : (w + 1 + ph) / 2;
		v = '{{7'h0, f}, 8'h04, 8'(ph), dst[7:0], dst[15:8], dst[23:16], 8'h10, 8'h00,
			8'(w - 1), 8'h00, 8'(h - 1), 8'h00, col[7:0], col[15:8], {6'h0, ln, 1'b0}};
		foreach (ra[i])
			apb(1'b1, ra[i], {24'h0, v[i]});
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0);
			cmp_byte("reg", v[i], rd[7:0]);
		end
		for (int y = 0; y < h; y++) begin
			for (int k = 0; k < nw; k++) begin
				wd = {rnd(), rnd()};
				if (wd[1:0] == 2'b00)
					wd = col;
				if (!f && wd[2])
					wd[7:0] = col[7:0];
				words.push_back(wd);
				for (int b = 0; b < 2; b++) begin
					ix = f ? k : k * 2 + b - ph;
					px = b ? wd[15:8] : wd[7:0];
					a = dst + 24'(ln ? y * w * (f + 1) : y * 32) + 24'(ix * (f + 1));
					if (f && b == 0 && wd != col)
						exp_q.push_back('{a, wd, 2'b11});
					if (!f && ix >= 0 && ix < w && px != col[7:0])
						exp_q.push_back('{a, {px, px}, {a[0], !a[0]}});
				end
			end
		end
		lag <= lg;
		apb(1'b1, 12'h400, 32'h80);
		poll(7, 1'b1);
		foreach (words[i]) begin
			poll(4, 1'b0);
			apb(1'b1, 12'h800, {16'h0, words[i]});
		end
		poll(3, 1'b1);
		cmp_byte("active", 8'h01, {7'h0, rd[7]});
		cmp_byte("left", 8'h00, 8'(exp_q.size()));
		apb(1'b0, 12'h800, 32'h0);
		apb(1'b0, 12'h400, 32'h0);
		cmp_byte("active", 8'h00, {7'h0, rd[7]});
		$display("test fmt %0d w %0d h %0d phase %0d linear %0d ended", f, w, h, ph, ln);
	endtask
	// Reset, register defaults, transfers
	initial begin
		lfsr_q = 8'h28;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lag = 4'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0);
			cmp_byte("reset", 8'h00, rd[7:0]);
		end
		apb(1'b0, 12'h3fc, 32'h0);
		cmp_byte("slverr", 8'h01, {7'h0, err});
		$display("test reset ended");
		blit(1'b1, 8, 4, 0, 1'b0, 4'hf);
		blit(1'b0, 5, 3, 0, 1'b1, 4'h0);
		blit(1'b0, 6, 2, 1, 1'b0, 4'h3);
		blit(1'b1, 3, 2, 0, 1'b1, 4'h1);
		complete_run();
	end
endmodule
`default_nettype wire
